// [rtl/flash_sequencer.sv]
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
// Command sequencer for erase suspend, password and sector protection
module flash_sequencer #(
  parameter int NSECT = 16,
  parameter int WINDOW_CYC = flash_pkg::WINDOW_CYC,
  parameter int LOCK_CYC = flash_pkg::LOCK_CYC,
  parameter int ERASE_CYC = flash_pkg::ERASE_CYC,
  parameter int CHIP_CYC = flash_pkg::CHIP_CYC,
  // Arbitrary identification value
  parameter logic [15:0] ID_CODE = 16'h5a5a
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [NSECT-1:0] persistent_protect_bit_i,
  input wire logic password_unlock_i,
  output logic busy_o,
  output logic suspended_o
);
  localparam int SW = $clog2(NSECT);
  localparam int TW = 20;
  localparam int TMAX = (1 << TW) - 1;

  if (NSECT < 4 || NSECT > 256 || (1 << SW) != NSECT || WINDOW_CYC < 1 ||
      WINDOW_CYC > TMAX || LOCK_CYC < 1 || LOCK_CYC > TMAX || ERASE_CYC < 1 ||
      ERASE_CYC > TMAX || CHIP_CYC < 1 || CHIP_CYC > TMAX ||
      flash_pkg::SUSP_CYC > flash_pkg::SUSP_MAX_CYC) begin : g_bad
    $error("flash_sequencer: unsupported parameters");
  end

  // Register index from a bus address, 7 when unmapped
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    case (a)
      flash_pkg::REG_CMD: reg_idx = 3'h0;
      flash_pkg::REG_ADDR: reg_idx = 3'h1;
      flash_pkg::REG_DATA: reg_idx = 3'h2;
      flash_pkg::REG_STATUS: reg_idx = 3'h3;
      flash_pkg::REG_RDATA: reg_idx = 3'h4;
      flash_pkg::REG_LOCKS: reg_idx = 3'h5;
      flash_pkg::REG_PROT: reg_idx = 3'h6;
      default: reg_idx = 3'h7;
    endcase
  endfunction

  flash_pkg::st_t state, next_state;
  flash_pkg::tgt_t tgt, next_tgt;
  logic [NSECT-1:0] mask, next_mask, dynamic_protect_bit, next_dpb, prot;
  logic [1:0] ebank, next_ebank;
  logic [15:0] addr, next_addr, data, next_data;
  logic fail, next_fail, tog6, next_tog6, tog2, next_tog2, dq0, next_dq0;
  logic pw_mode, next_pw_mode, ps_mode, next_ps_mode;
  logic sec_prot, next_sec_prot, freeze, next_freeze;
  logic ack, next_ack;
  logic [31:0] rd, next_rd;
  logic req, wr, rd_hit, cmd_wr, marked, sprot, bank_hit, busy, erase_st;
  logic [2:0] ridx;
  logic [7:0] code, status;
  logic [SW-1:0] sect;
  logic [15:0] rword, pw_word;
  logic op_load, op_done, op_active, er_load, er_run, er_done;
  logic [TW-1:0] op_val;
  logic pw_wr, pw_clash;

  op_timer #(.W(TW)) u_op_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .load_i(op_load),
    .value_i(op_val),
    .run_i(1'b1),
    .done_o(op_done),
    .active_o(op_active)
  );

  // Erase time pauses while suspended so resume continues where it stopped
  op_timer #(.W(TW)) u_erase_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .load_i(er_load),
    .value_i(TW'(ERASE_CYC)),
    .run_i(er_run),
    .done_o(er_done),
    .active_o()
  );

  password_store u_password_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_i(pw_wr),
    .idx_i(addr[1:0]),
    .data_i(data),
    .word_o(pw_word),
    .clash_o(pw_clash)
  );

  assign req = cyc_i && stb_i && !ack;
  assign ridx = reg_idx(adr_i);
  assign wr = req && we_i;
  assign rd_hit = req && !we_i && (ridx == 3'h3 || ridx == 3'h4);
  assign cmd_wr = wr && ridx == 3'h0 && sel_i[0];
  assign code = dat_i[7:0];
  assign sect = addr[flash_pkg::ADDR_SECT_LSB +: SW];
  assign bank_hit = sect[SW-1 -: 2] == ebank;
  assign prot = persistent_protect_bit_i | dynamic_protect_bit; // R21
  assign sprot = prot[sect];
  assign marked = mask[sect];
  assign er_run = state == flash_pkg::ST_ERASING;
  assign erase_st = state == flash_pkg::ST_ERASE_WAIT || state == flash_pkg::ST_ERASING ||
                    state == flash_pkg::ST_SUSPENDING || state == flash_pkg::ST_SUSP_READ ||
                    state == flash_pkg::ST_SUSP_PROG || state == flash_pkg::ST_SUSP_AUTO;
  assign suspended_o = state == flash_pkg::ST_SUSP_READ || state == flash_pkg::ST_SUSP_PROG ||
                       state == flash_pkg::ST_SUSP_AUTO;
  always_comb begin
    case (state)
      flash_pkg::ST_ERASE_WAIT, flash_pkg::ST_ERASING, flash_pkg::ST_SUSPENDING,
      flash_pkg::ST_SUSP_PROG, flash_pkg::ST_PROG, flash_pkg::ST_CHIP,
      flash_pkg::ST_LOCK_WAIT: busy = 1'b1;
      flash_pkg::ST_PW_PROG: busy = op_active;
      default: busy = 1'b0;
    endcase
  end
  assign busy_o = busy;
  // Suspended reads show bit 7 high, active erase shows it low
  assign status = {state == flash_pkg::ST_SUSP_READ, tog6, fail, 1'b0,
                   state != flash_pkg::ST_ERASE_WAIT, tog2, 1'b0, dq0}; // R5

  always_comb begin
    case (state)
      flash_pkg::ST_PW_VERIFY: rword = pw_mode ? 16'hffff : pw_word; // R12 R13
      flash_pkg::ST_DPB_STAT: rword = {15'h0000, dynamic_protect_bit[sect]};
      flash_pkg::ST_LOCK_DONE: rword = {15'h0000, dq0};
      flash_pkg::ST_AUTOSEL, flash_pkg::ST_SUSP_AUTO: rword = ID_CODE;
      default: rword = (busy || (erase_st && marked)) ? {8'h00, status} : 16'h0000; // R5 R9
    endcase
  end

  always_comb begin
    next_ack = req;
    next_rd = rd;
    if (req && !we_i) begin
      case (ridx)
        3'h1: next_rd = {16'h0000, addr};
        3'h2: next_rd = {16'h0000, data};
        3'h3: next_rd = {23'h000000, busy, status};
        3'h4: next_rd = {16'h0000, rword};
        3'h5: next_rd = {28'h0000000, sec_prot, freeze | pw_mode, ps_mode, pw_mode}; // R19
        3'h6: next_rd = {29'h00000000, persistent_protect_bit_i[sect], dynamic_protect_bit[sect], sprot};
        default: next_rd = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rd <= 32'h00000000;
    end else if (ce_i) begin
      ack <= next_ack;
      rd <= next_rd;
    end
  end
  assign ack_o = ack;
  assign dat_o = rd;

  always_comb begin
    next_state = state;
    next_tgt = tgt;
    next_mask = mask;
    next_dpb = dynamic_protect_bit;
    next_ebank = ebank;
    next_addr = addr;
    next_data = data;
    next_fail = fail;
    next_tog6 = tog6;
    next_tog2 = tog2;
    next_dq0 = dq0;
    next_pw_mode = pw_mode;
    next_ps_mode = ps_mode;
    next_sec_prot = sec_prot;
    next_freeze = freeze;
    op_load = 1'b0;
    op_val = TW'(flash_pkg::PROG_CYC);
    er_load = 1'b0;
    pw_wr = 1'b0;
    if (wr && ridx == 3'h1) begin
      if (sel_i[0]) next_addr[7:0] = dat_i[7:0];
      if (sel_i[1]) next_addr[15:8] = dat_i[15:8];
    end
    if (wr && ridx == 3'h2) begin
      if (sel_i[0]) next_data[7:0] = dat_i[7:0];
      if (sel_i[1]) next_data[15:8] = dat_i[15:8];
    end
    if (rd_hit && busy && state != flash_pkg::ST_SUSP_READ) begin
      next_tog6 = !tog6;
    end
    if (rd_hit && marked && erase_st && state != flash_pkg::ST_SUSP_PROG) begin
      next_tog2 = !tog2;
    end
    if (password_unlock_i) begin
      next_freeze = 1'b0; // R18
    end
    case (state)
      flash_pkg::ST_READ: begin
        if (cmd_wr) begin
          case (code)
            flash_pkg::CMD_RESET: next_fail = 1'b0;
            flash_pkg::CMD_SECT_ERASE: begin
              if (sprot) begin
                next_fail = 1'b1; // R25
              end else begin
                next_mask[sect] = 1'b1;
                next_ebank = sect[SW-1 -: 2];
                op_load = 1'b1;
                op_val = TW'(WINDOW_CYC);
                next_state = flash_pkg::ST_ERASE_WAIT;
              end
            end
            flash_pkg::CMD_CHIP_ERASE: begin
              op_load = 1'b1;
              op_val = TW'(CHIP_CYC);
              next_state = flash_pkg::ST_CHIP;
            end
            flash_pkg::CMD_PROGRAM: begin
              if (sprot) begin
                next_fail = 1'b1; // R25
              end else begin
                op_load = 1'b1;
                next_state = flash_pkg::ST_PROG;
              end
            end
            flash_pkg::CMD_PW_PROG: begin
              if (pw_mode) begin
                next_fail = 1'b1; // R15
              end else begin
                pw_wr = 1'b1; // R8
                next_fail = pw_clash; // R10
                op_load = 1'b1;
                op_val = TW'(flash_pkg::PW_PROG_CYC);
                next_state = flash_pkg::ST_PW_PROG;
              end
            end
            flash_pkg::CMD_PW_VERIFY: next_state = flash_pkg::ST_PW_VERIFY; // R13
            flash_pkg::CMD_LOCK_PROG: begin
              if (addr == flash_pkg::password_lock_cycle_address && !ps_mode) begin
                next_tgt = flash_pkg::TGT_PW; // R14 R16
                op_load = 1'b1;
                op_val = TW'(LOCK_CYC);
                next_state = flash_pkg::ST_LOCK_WAIT;
              end else if (addr == flash_pkg::persistent_lock_cycle_address && !pw_mode) begin
                next_tgt = flash_pkg::TGT_PS; // R15 R16
                op_load = 1'b1;
                op_val = TW'(LOCK_CYC);
                next_state = flash_pkg::ST_LOCK_WAIT;
              end else begin
                next_fail = 1'b1;
              end
            end
            flash_pkg::CMD_FREEZE_SET: begin
              next_freeze = 1'b1;
              next_dpb = persistent_protect_bit_i; // R18
            end
            flash_pkg::CMD_SEC_ENTER: next_state = flash_pkg::ST_SECURE;
            flash_pkg::CMD_DPB_ENTER: next_state = flash_pkg::ST_DPB_WRITE; // R20
            flash_pkg::CMD_DPB_STATUS: next_state = flash_pkg::ST_DPB_STAT;
            flash_pkg::CMD_AUTOSEL: next_state = flash_pkg::ST_AUTOSEL;
            default: next_state = flash_pkg::ST_READ;
          endcase
        end
      end
      flash_pkg::ST_ERASE_WAIT: begin
        if (cmd_wr && code == flash_pkg::CMD_SECT_ERASE) begin
          if (sprot) begin
            next_fail = 1'b1; // R25
          end else begin
            next_mask[sect] = 1'b1;
            op_load = 1'b1;
            op_val = TW'(WINDOW_CYC);
          end
        end else if (cmd_wr && code == flash_pkg::CMD_SUSPEND && bank_hit) begin
          op_load = 1'b1;
          op_val = '0;
          er_load = 1'b1;
          next_state = flash_pkg::ST_SUSP_READ; // R1 R4
        end else if (cmd_wr) begin
          op_load = 1'b1;
          op_val = '0;
          next_mask = '0;
          next_state = flash_pkg::ST_READ; // R23
        end else if (op_done) begin
          er_load = 1'b1;
          next_state = flash_pkg::ST_ERASING;
        end
      end
      flash_pkg::ST_ERASING: begin
        if (er_done) begin
          next_mask = '0;
          next_state = flash_pkg::ST_READ;
        end else if (cmd_wr && code == flash_pkg::CMD_SUSPEND && bank_hit) begin
          op_load = 1'b1;
          op_val = TW'(flash_pkg::SUSP_CYC);
          next_state = flash_pkg::ST_SUSPENDING; // R1 R3
        end
      end
      flash_pkg::ST_SUSPENDING: begin
        if (op_done) next_state = flash_pkg::ST_SUSP_READ; // R3
      end
      flash_pkg::ST_SUSP_READ: begin
        if (cmd_wr && code == flash_pkg::CMD_RESUME && bank_hit) begin
          next_state = flash_pkg::ST_ERASING; // R7
        end else if (cmd_wr && code == flash_pkg::CMD_PROGRAM) begin
          if (marked || sprot) begin
            next_fail = 1'b1; // R5 R25
          end else begin
            op_load = 1'b1;
            next_state = flash_pkg::ST_SUSP_PROG; // R5
          end
        end else if (cmd_wr && code == flash_pkg::CMD_AUTOSEL) begin
          next_state = flash_pkg::ST_SUSP_AUTO; // R6
        end else if (cmd_wr && code == flash_pkg::CMD_RESET) begin
          next_fail = 1'b0;
        end
        // A second suspend falls through untouched R24
      end
      flash_pkg::ST_SUSP_PROG: begin
        if (op_done) next_state = flash_pkg::ST_SUSP_READ; // R6
      end
      flash_pkg::ST_SUSP_AUTO: begin
        if (cmd_wr && code == flash_pkg::CMD_RESET) next_state = flash_pkg::ST_SUSP_READ;
      end
      // Commands during chip erase and word program are dropped R2
      flash_pkg::ST_PROG, flash_pkg::ST_CHIP: begin
        if (op_done) next_state = flash_pkg::ST_READ;
      end
      flash_pkg::ST_PW_PROG: begin
        if (cmd_wr && code == flash_pkg::CMD_SEC_EXIT && !op_active) begin
          next_state = flash_pkg::ST_READ; // R9
        end else if (cmd_wr && code == flash_pkg::CMD_PW_PROG && !op_active) begin
          pw_wr = 1'b1; // R8
          next_fail = pw_clash; // R10
          op_load = 1'b1;
          op_val = TW'(flash_pkg::PW_PROG_CYC);
        end
      end
      flash_pkg::ST_PW_VERIFY, flash_pkg::ST_DPB_STAT: begin
        if (cmd_wr && code == flash_pkg::CMD_SEC_EXIT) next_state = flash_pkg::ST_READ; // R13 R22
      end
      flash_pkg::ST_SECURE: begin
        if (cmd_wr && code == flash_pkg::CMD_LOCK_VERIFY &&
            addr == flash_pkg::secure_region_protect_address) begin
          next_tgt = flash_pkg::TGT_SEC; // R17
          op_load = 1'b1;
          op_val = TW'(LOCK_CYC);
          next_state = flash_pkg::ST_LOCK_WAIT;
        end else if (cmd_wr && code == flash_pkg::CMD_SEC_EXIT) begin
          next_state = flash_pkg::ST_READ;
        end
      end
      flash_pkg::ST_LOCK_WAIT: begin
        if (op_done) begin
          case (tgt)
            flash_pkg::TGT_PW: next_pw_mode = !ps_mode; // R14 R16
            flash_pkg::TGT_PS: next_ps_mode = !pw_mode; // R15 R16
            default: next_sec_prot = 1'b1; // R17
          endcase
          next_state = flash_pkg::ST_LOCK_DONE;
        end
      end
      flash_pkg::ST_LOCK_DONE: begin
        if (cmd_wr && code == flash_pkg::CMD_LOCK_VERIFY) begin
          case (tgt)
            flash_pkg::TGT_PW: next_dq0 = pw_mode; // R14
            flash_pkg::TGT_PS: next_dq0 = ps_mode; // R16
            default: next_dq0 = sec_prot; // R17
          endcase
        end else if (cmd_wr && code == flash_pkg::CMD_LOCK_PROG && tgt != flash_pkg::TGT_SEC) begin
          op_load = 1'b1;
          op_val = TW'(LOCK_CYC);
          next_state = flash_pkg::ST_LOCK_WAIT;
        end else if (cmd_wr && code == flash_pkg::CMD_SEC_EXIT) begin
          next_dq0 = 1'b0;
          next_state = flash_pkg::ST_READ;
        end
      end
      flash_pkg::ST_DPB_WRITE: begin
        if (cmd_wr && code == flash_pkg::CMD_DPB_SET) begin
          next_dpb[sect] = 1'b1; // R20
        end else if (cmd_wr && code == flash_pkg::CMD_DPB_CLR) begin
          next_dpb[sect] = 1'b0; // R20
        end else if (cmd_wr && code == flash_pkg::CMD_RESET) begin
          next_state = flash_pkg::ST_READ; // R22
        end
      end
      flash_pkg::ST_AUTOSEL: begin
        if (cmd_wr && code == flash_pkg::CMD_RESET) next_state = flash_pkg::ST_READ;
      end
      default: next_state = flash_pkg::ST_READ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= flash_pkg::ST_READ;
      tgt <= flash_pkg::TGT_PW;
      mask <= '0;
      dynamic_protect_bit <= '0; // R22
      ebank <= 2'h0;
      addr <= 16'h0000;
      data <= 16'h0000;
      fail <= 1'b0;
      tog6 <= 1'b0;
      tog2 <= 1'b0;
      dq0 <= 1'b0;
      pw_mode <= 1'b0;
      ps_mode <= 1'b0;
      sec_prot <= 1'b0;
      freeze <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      tgt <= next_tgt;
      mask <= next_mask;
      dynamic_protect_bit <= next_dpb;
      ebank <= next_ebank;
      addr <= next_addr;
      data <= next_data;
      fail <= next_fail;
      tog6 <= next_tog6;
      tog2 <= next_tog2;
      dq0 <= next_dq0;
      pw_mode <= next_pw_mode;
      ps_mode <= next_ps_mode;
      sec_prot <= next_sec_prot;
      freeze <= next_freeze;
    end
  end
endmodule

// [rtl/flash_pkg.sv]
// Constants and types for the flash command sequencer
// Functional notes
// R1 - Suspend code with bank address accepted only during sector erase or its time-out
// R2 - Suspend is ignored during chip erase or during word programming
// R3 - Suspend during active erasure reaches suspended state within 35 us
// R4 - Suspend during erase time-out ends the window at once, no erasure started
// R5 - Suspended bank serves unmarked sectors; marked sectors read back status bits
// R6 - Program in suspend returns to suspended-read; autoselect accepted there too
// R7 - Resume needs the suspended bank; repeats ignored; suspend allowed again after
// R8 - Password written as four word sequences in any address order
// R9 - Password programming blocks other access, reads give status, exit on secure exit
// R10 - Password bits only clear; setting a zero bit times out and stays zero
// R11 - Password holds all ones after reset; any value is a valid password
// R12 - Password readback only while password-mode lock clear, else all ones
// R13 - Password verify returns word picked by two low address bits until exit
// R14 - Password-mode lock: 68h, wait 150 us, 48h, data bit 0 shows success
// R15 - Password-mode lock permanent, blocks verify, update and persistent-mode lock
// R16 - Persistent-mode lock set likewise and then blocks the password-mode lock
// R17 - Secure sector protected by 48h, wait 150 us, 48h, bit 0 check
// R18 - Freeze bit has no clear but unlock or power-on; set copies persistent into dynamic
// R19 - Freeze reads set whenever password-mode lock is programmed
// R20 - Dynamic bit write selects sector by high address, 01h sets, 00h clears
// R21 - Sector protected when persistent bit set or dynamic bit set
// R22 - Dynamic bits clear on reset; write mode ends on reset cmd, status on exit
// R23 - Other command in erase time-out aborts to read mode
// R24 - Suspend while already suspended has no effect
// R25 - Program or erase of a protected sector fails and shows in status
package flash_pkg;
  localparam int CLK_NS = 10;
  localparam int WINDOW_NS = 50000;
  localparam int WINDOW_CYC = (WINDOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_NS = 150000;
  localparam int LOCK_CYC = (LOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSP_MAX_NS = 35000;
  localparam int SUSP_MAX_CYC = SUSP_MAX_NS / CLK_NS;
  localparam int SUSP_CYC = 16;
  localparam int PROG_CYC = 200;
  localparam int PW_PROG_CYC = 100;
  localparam int ERASE_CYC = 50000;
  localparam int CHIP_CYC = 200000;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_LOCKS = 8'h14;
  localparam logic [7:0] REG_PROT = 8'h18;
  localparam int ADDR_SECT_LSB = 8;
  localparam logic [15:0] PW_RESET = 16'hffff;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PW_PROG = 8'h38;
  localparam logic [7:0] CMD_PW_VERIFY = 8'hc8;
  localparam logic [7:0] CMD_LOCK_PROG = 8'h68;
  localparam logic [7:0] CMD_LOCK_VERIFY = 8'h48;
  localparam logic [7:0] CMD_FREEZE_SET = 8'h58;
  localparam logic [7:0] CMD_SEC_ENTER = 8'h88;
  localparam logic [7:0] CMD_SEC_EXIT = 8'h9c;
  localparam logic [7:0] CMD_DPB_ENTER = 8'he0;
  localparam logic [7:0] CMD_DPB_STATUS = 8'he8;
  localparam logic [7:0] CMD_DPB_SET = 8'h01;
  localparam logic [7:0] CMD_DPB_CLR = 8'h00;
  localparam logic [15:0] password_lock_cycle_address = 16'h000a;
  localparam logic [15:0] persistent_lock_cycle_address = 16'h0012;
  localparam logic [15:0] secure_region_protect_address = 16'h001a;
  typedef enum logic [4:0] {
    ST_READ, ST_ERASE_WAIT, ST_ERASING, ST_SUSPENDING, ST_SUSP_READ,
    ST_SUSP_PROG, ST_SUSP_AUTO, ST_PROG, ST_CHIP, ST_PW_PROG, ST_PW_VERIFY,
    ST_SECURE, ST_LOCK_WAIT, ST_LOCK_DONE, ST_DPB_WRITE, ST_DPB_STAT, ST_AUTOSEL
  } st_t;
  typedef enum logic [1:0] {TGT_PW, TGT_PS, TGT_SEC} tgt_t;
endpackage

// [rtl/op_timer.sv]
`timescale 1ns/1ps
// Down counter that times one operation and can pause
module op_timer #(
  parameter int W = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  input wire logic run_i,
  output logic done_o,
  output logic active_o
);
  logic [W-1:0] cnt, next_cnt;
  assign done_o = run_i && !load_i && cnt == W'(1);
  assign active_o = cnt != '0;
  always_comb begin
    next_cnt = cnt;
    if (load_i) begin
      next_cnt = value_i;
    end else if (run_i && active_o) begin
      next_cnt = cnt - W'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (ce_i) begin
      cnt <= next_cnt;
    end
  end
endmodule

// [rtl/password_store.sv]
`timescale 1ns/1ps
// Four-word password store whose bits can only be cleared
module password_store (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [1:0] idx_i,
  input wire logic [15:0] data_i,
  output logic [15:0] word_o,
  output logic clash_o
);
  logic [15:0] pw [4];
  logic [15:0] next_pw [4];
  assign word_o = pw[idx_i];
  // A one over a cleared bit cannot be written back
  assign clash_o = |(data_i & ~pw[idx_i]); // R10
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_pw[i] = pw[i];
    end
    if (wr_i) begin
      next_pw[idx_i] = pw[idx_i] & data_i; // R10
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        pw[i] <= flash_pkg::PW_RESET; // R11
      end
    end else if (ce_i) begin
      for (int i = 0; i < 4; i++) begin
        pw[i] <= next_pw[i];
      end
    end
  end
endmodule

// [testbench/flash_sequencer_props.sv]
// Sequencer port checks
`timescale 1ns/1ps
module flash_sequencer_props (
  input logic clk_i,
  input logic rst_i,
  input logic ce_i,
  input logic cyc_i,
  input logic stb_i,
  input logic we_i,
  input logic [7:0] adr_i,
  input logic [31:0] dat_i,
  input logic [31:0] dat_o,
  input logic ack_o,
  input logic suspended_o
);
  logic req, cmdw;
  logic [11:0] since, next_since;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign req = cyc_i && stb_i && !ack_o && ce_i;
  assign cmdw = req && we_i && adr_i == flash_pkg::REG_CMD;
  // Saturates so idle never wraps
  always_comb next_since = (rst_i || since == 12'hfff) ? 12'hfff : since + 12'h001;
  always_ff @(posedge clk_i) since <= cmdw ? 12'h000 : next_since;
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_answer: assert property (req |=> ack_o) else $error("no ack");
  a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
  a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !suspended_o) else $error("busy reset");
  a_unmapped_zero: assert property (req && !we_i && adr_i > 8'h18 |=> dat_o == 32'h0)
    else $error("unmapped nonzero");
  a_susp_bound: assert property ($rose(suspended_o) |-> since <= 12'hdac)
    else $error("slow suspend");
  a_susp_again: assert property (suspended_o && cmdw && dat_i[7:0] == 8'hb0 |=> suspended_o [*2])
    else $error("suspend lost");
  a_resume_cause: assert property ($fell(suspended_o) |-> since <= 12'h002)
    else $error("stray resume");
endmodule

// [testbench/flash_host.sv]
// Host Wishbone master model
`timescale 1ns/1ps
module flash_host (
  input logic clk_i,
  input logic ack_i,
  input logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o
);
  bit hung = 0;
  initial {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    hung = hung | (ack_i !== 1'b1);
    q = rdat_i;
    {cyc_o, stb_o} <= 2'b00;
    @(posedge clk_i);
  endtask
  // Address goes ahead of every code
  task automatic cmd(input logic [15:0] a, input logic [7:0] c);
    logic [31:0] q;
    xfer(1'b1, flash_pkg::REG_ADDR, {16'h0000, a}, q);
    xfer(1'b1, flash_pkg::REG_CMD, {24'h000000, c}, q);
  endtask
endmodule

// [testbench/flash_suspend_and_sector_protection_tb.sv]
// Bench for the flash sequencer
`timescale 1ns/1ps
module flash_suspend_and_sector_protection_tb;
  logic clk_i = 0, rst_i = 1, ce = 1, unlock = 0;
  logic cyc_i, stb_i, we_i, ack_o, busy_o, suspended_o;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [15:0] persistent_protect_bit = 16'h0020;
  int error_cnt = 0, tests_run = 0;
  initial forever #5 clk_i = ~clk_i;
  flash_host host (.clk_i, .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
    .we_o(we_i), .adr_o(adr_i), .dat_o(dat_i));
  flash_sequencer #(.WINDOW_CYC(20), .LOCK_CYC(20), .ERASE_CYC(50), .CHIP_CYC(50)) DUT (
    .clk_i, .rst_i, .ce_i(ce), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o,
    .ack_o, .persistent_protect_bit_i(persistent_protect_bit), .password_unlock_i(unlock), .busy_o, .suspended_o);
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) if (host.hung) begin
    error_cnt++;
    test_done();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic sus(input logic e);
    chk({31'h0, suspended_o}, {31'h0, e});
  endtask
  task automatic ex();
    host.cmd(16'h0002, flash_pkg::CMD_SEC_EXIT);
  endtask
  task automatic idle();
    for (int n = 0; n < 500 && busy_o !== 1'b0; n++) @(posedge clk_i);
    host.hung = host.hung | (busy_o !== 1'b0);
  endtask
  task automatic s_protect();
    host.cmd(16'h0300, flash_pkg::CMD_DPB_ENTER);
    host.cmd(16'h0300, flash_pkg::CMD_DPB_SET);
    rchk(flash_pkg::REG_PROT, 32'h7, 32'h3);
    host.cmd(16'h0300, flash_pkg::CMD_DPB_CLR);
    rchk(flash_pkg::REG_PROT, 32'h7, 32'h0);
    host.cmd(16'h0500, flash_pkg::CMD_RESET);
    rchk(flash_pkg::REG_PROT, 32'h7, 32'h5);
    host.cmd(16'h0500, flash_pkg::CMD_PROGRAM);
    idle();
    rchk(flash_pkg::REG_STATUS, 32'h20, 32'h20);
    host.cmd(16'h0500, flash_pkg::CMD_RESET);
  endtask
  task automatic s_suspend();
    host.cmd(16'h0000, flash_pkg::CMD_SECT_ERASE);
    host.cmd(16'h0000, flash_pkg::CMD_SUSPEND);
    sus(1'b1);
    rchk(flash_pkg::REG_STATUS, 32'h80, 32'h80);
    host.cmd(16'h0000, flash_pkg::CMD_SUSPEND);
    sus(1'b1);
    host.cmd(16'h0000, flash_pkg::CMD_RESUME);
    sus(1'b0);
    repeat (25) @(posedge clk_i);
    host.cmd(16'h0000, flash_pkg::CMD_SUSPEND);
    repeat (16) @(posedge clk_i);
    sus(1'b1);
    host.cmd(16'h0000, flash_pkg::CMD_RESUME);
    idle();
    host.cmd(16'h0000, flash_pkg::CMD_CHIP_ERASE);
    host.cmd(16'h0000, flash_pkg::CMD_SUSPEND);
    sus(1'b0);
    idle();
    rchk(8'h1c, 32'hffffffff, 32'h0);
  endtask
  task automatic s_password();
    host.cmd(16'h0f02, flash_pkg::CMD_PW_VERIFY);
    rchk(flash_pkg::REG_RDATA, 32'hffff, 32'hffff);
    ex();
    host.xfer(1'b1, flash_pkg::REG_DATA, 32'h1234, q);
    host.cmd(16'h0002, flash_pkg::CMD_PW_PROG);
    idle();
    ex();
    host.xfer(1'b1, flash_pkg::REG_DATA, 32'hffff, q);
    host.cmd(16'h0002, flash_pkg::CMD_PW_PROG);
    idle();
    ex();
    host.cmd(16'h0f02, flash_pkg::CMD_PW_VERIFY);
    rchk(flash_pkg::REG_RDATA, 32'hffff, 32'h1234);
    ex();
    host.cmd(flash_pkg::password_lock_cycle_address, flash_pkg::CMD_LOCK_PROG);
    repeat (20) @(posedge clk_i);
    host.cmd(flash_pkg::password_lock_cycle_address, flash_pkg::CMD_LOCK_VERIFY);
    rchk(flash_pkg::REG_RDATA, 32'h1, 32'h1);
    ex();
    host.cmd(flash_pkg::persistent_lock_cycle_address, flash_pkg::CMD_LOCK_PROG);
    repeat (20) @(posedge clk_i);
    ex();
    rchk(flash_pkg::REG_LOCKS, 32'h7, 32'h5);
    host.cmd(16'h0002, flash_pkg::CMD_PW_VERIFY);
    rchk(flash_pkg::REG_RDATA, 32'hffff, 32'hffff);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    s_protect();
    s_suspend();
    s_password();
    test_done();
  end
endmodule
bind flash_sequencer flash_sequencer_props P (.*);
